/* include/slt_pkg.sv */
package slt_pkg;

  // register byte addresses: printed offsets are not all multiples of four, so index*4
  localparam logic [11:0] TEST_IDX      = 12'h205;
  localparam logic [11:0] LINKID_IDX    = 12'h206;
  localparam logic [11:0] COMMA_IDX     = 12'h207;
  localparam logic [11:0] CTRL_IDX      = 12'h210;
  localparam logic [11:0] STAT_IDX      = 12'h211;
  localparam logic [13:0] TEST_ADDR     = {TEST_IDX, 2'b00};
  localparam logic [13:0] LINKID_ADDR   = {LINKID_IDX, 2'b00};
  localparam logic [13:0] COMMA_ADDR    = {COMMA_IDX, 2'b00};
  localparam logic [13:0] CTRL_ADDR     = {CTRL_IDX, 2'b00};
  localparam logic [13:0] STAT_ADDR     = {STAT_IDX, 2'b00};

  localparam logic [4:0]  TEST_RESET    = 5'h00;
  localparam logic [7:0]  LINKID_RESET  = 8'h00;
  localparam logic [1:0]  COMMA_RESET   = 2'h0;

  // control register fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_LINKB_BIT = 1;
  localparam int          CTRL_CODE_BIT = 2;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // 8b/10b characters, 8-bit value with control flag
  localparam logic [7:0]  CHAR_K28_1    = 8'h3c;
  localparam logic [7:0]  CHAR_K28_5    = 8'hbc;
  localparam logic [7:0]  CHAR_K28_7    = 8'hfc;
  localparam logic [7:0]  CHAR_D21_5    = 8'hb5;
  localparam logic [15:0] CLOCK_PATTERN = 16'h00ff;

  typedef enum logic [4:0] {
    TP_NORMAL  = 5'h00,
    TP_PRBS7   = 5'h01,
    TP_PRBS15  = 5'h02,
    TP_PRBS23  = 5'h03,
    TP_RAMP    = 5'h04,
    TP_TRANSPORT = 5'h05,
    TP_D21_5   = 5'h06,
    TP_K28_5   = 5'h07,
    TP_ILA_REP = 5'h08,
    TP_RPAT    = 5'h09,
    TP_LOW     = 5'h0a,
    TP_HIGH    = 5'h0b,
    TP_PRBS9   = 5'h0d,
    TP_PRBS31  = 5'h0e,
    TP_CLOCK   = 5'h0f,
    TP_K28_7   = 5'h10
  } slt_pattern_t;

  typedef enum logic [3:0] {
    SRC_DATA, SRC_PRBS, SRC_RAMP, SRC_TRANSPORT, SRC_CHAR, SRC_ILA,
    SRC_RPAT, SRC_LOW, SRC_HIGH, SRC_CLOCK
  } slt_source_t;

  typedef struct packed {
    slt_source_t source;
    logic [4:0]  prbsOrder;
    logic [7:0]  character;
    logic        isControl;
  } slt_lane_cfg_t;

  typedef struct packed {
    logic [7:0] linkIdA;
    logic [7:0] linkIdB;
    logic [7:0] eofChar;
    logic       eofEnable;
  } slt_ila_cfg_t;

endpackage

/* hdl/slt_test_ila_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - a 5-bit pattern selector resets to zero, and zero leaves the lanes carrying normal data.
// - selector 1, 2, 3, 13 and 14 choose PRBS7, PRBS15, PRBS23, PRBS9 and PRBS31.
// - selector 4 gives a ramp and selector 5 the transport layer pattern.
// - selector 6 sends D21.5, 7 sends K28.5 and 16 sends K28.7 continuously.
// - selector 8 repeats the lane alignment sequence and 9 sends the modified RPAT pattern.
// - selector 10 holds every serial output low and 11 holds it high.
// - selector 15 sends the 0x00FF clock pattern of eight zeros and eight ones.
// - selections 7, 8, 9 and 16 are only valid with 8b/10b coding, so other codings fall back to normal.
// - an 8-bit link identifier is sent in the second multiframe of the alignment sequence.
// - link A sends the identifier as stored, link B sends it plus one.
// - identifier bit 0 is dropped, stored and read back as zero.
// - in 8b/10b the chosen comma marks end-of-frame opportunistically, and does nothing in other codings.
// - comma choice 0 picks K28.7, 1 picks K28.1, 2 picks K28.5, and 3 is reserved.
module slt_test_ila_ctrl #(
  parameter int ADDR_WIDTH = 14
) (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output slt_pkg::slt_lane_cfg_t         laneCfg,
  output slt_pkg::slt_ila_cfg_t          ilaCfg,
  output logic                           serialLinkEnable
);

  if (ADDR_WIDTH < 14 || ADDR_WIDTH > 32) begin : g_width_check
    $error("slt_test_ila_ctrl: ADDR_WIDTH must be 14..32");
  end

  logic [4:0]            linkTestPatternSelect_reg;
  logic [7:0]            ilaLinkIdentifier_reg;
  logic [1:0]            endOfFrameCommaSelect_reg;
  logic                  serialLinkEnable_reg;
  logic                  linkBSide_reg;
  logic                  linkModeIs8b10b_reg;
  logic                  awHeld_reg;
  logic                  wHeld_reg;
  logic [ADDR_WIDTH-1:0] awAddr_reg;
  logic [31:0]           wData_reg;
  logic [3:0]            wStrb_reg;
  logic                  writeNow;
  logic [ADDR_WIDTH-1:0] writeAddr;
  logic [31:0]           writeData;
  logic [3:0]            writeStrb;
  logic                  writeHit;
  logic                  writeTake;
  logic                  readHit;
  logic [31:0]           readValue;
  slt_pkg::slt_lane_cfg_t laneCfg_next;
  slt_pkg::slt_ila_cfg_t  ilaCfg_next;

  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
    isMapped = addr[ADDR_WIDTH-1:0] == ADDR_WIDTH'(slt_pkg::TEST_ADDR)
            || addr == ADDR_WIDTH'(slt_pkg::LINKID_ADDR)
            || addr == ADDR_WIDTH'(slt_pkg::COMMA_ADDR)
            || addr == ADDR_WIDTH'(slt_pkg::CTRL_ADDR)
            || addr == ADDR_WIDTH'(slt_pkg::STAT_ADDR);
  endfunction

  // both channels may arrive in either order; hold each until its partner shows up
  assign writeAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  assign writeData = wHeld_reg ? wData_reg : s_axi_wdata;
  assign writeStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  assign writeNow  = (awHeld_reg || (s_axi_awvalid && s_axi_awready))
                  && (wHeld_reg || (s_axi_wvalid && s_axi_wready));
  assign writeHit  = writeNow && isMapped(writeAddr);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= '0;
      wData_reg     <= '0;
      wStrb_reg     <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (writeNow) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
      end else begin
        awHeld_reg <= awHeld_reg || (s_axi_awvalid && s_axi_awready);
        wHeld_reg  <= wHeld_reg || (s_axi_wvalid && s_axi_wready);
      end
      // one write in flight: each ready only when its own channel holds nothing and no response pending
      s_axi_awready <= !s_axi_awready && !awHeld_reg && !s_axi_bvalid && !writeNow && s_axi_awvalid;
      s_axi_wready  <= !s_axi_wready && !wHeld_reg && !s_axi_bvalid && !writeNow && s_axi_wvalid;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= slt_pkg::RESP_OKAY;
    end else if (writeNow) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= writeHit ? slt_pkg::RESP_OKAY : slt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // registers; only byte lane 0 carries data, upper bits read as zero
  // no lockout while enabled: software keeps to the disabled window
  assign writeTake = writeHit && writeStrb[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      linkTestPatternSelect_reg <= slt_pkg::TEST_RESET;
    end else if (writeTake && writeAddr == ADDR_WIDTH'(slt_pkg::TEST_ADDR)) begin
      linkTestPatternSelect_reg <= writeData[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ilaLinkIdentifier_reg <= slt_pkg::LINKID_RESET;
    end else if (writeTake && writeAddr == ADDR_WIDTH'(slt_pkg::LINKID_ADDR)) begin
      ilaLinkIdentifier_reg <= {writeData[7:1], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      endOfFrameCommaSelect_reg <= slt_pkg::COMMA_RESET;
    end else if (writeTake && writeAddr == ADDR_WIDTH'(slt_pkg::COMMA_ADDR)) begin
      endOfFrameCommaSelect_reg <= writeData[1:0];
    end
  end

  // coding defaults to 8b/10b so character patterns are usable straight out of reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      serialLinkEnable_reg <= 1'b0;
      linkBSide_reg        <= 1'b0;
      linkModeIs8b10b_reg  <= 1'b1;
    end else if (writeTake && writeAddr == ADDR_WIDTH'(slt_pkg::CTRL_ADDR)) begin
      serialLinkEnable_reg <= writeData[slt_pkg::CTRL_EN_BIT];
      linkBSide_reg        <= writeData[slt_pkg::CTRL_LINKB_BIT];
      linkModeIs8b10b_reg  <= writeData[slt_pkg::CTRL_CODE_BIT];
    end
  end

  assign readHit = isMapped(s_axi_araddr);

  always_comb begin
    readValue = 32'h0000_0000;
    if (s_axi_araddr == ADDR_WIDTH'(slt_pkg::TEST_ADDR)) begin
      readValue[4:0] = linkTestPatternSelect_reg;
    end else if (s_axi_araddr == ADDR_WIDTH'(slt_pkg::LINKID_ADDR)) begin
      readValue[7:0] = ilaLinkIdentifier_reg;
    end else if (s_axi_araddr == ADDR_WIDTH'(slt_pkg::COMMA_ADDR)) begin
      readValue[1:0] = endOfFrameCommaSelect_reg;
    end else if (s_axi_araddr == ADDR_WIDTH'(slt_pkg::CTRL_ADDR)) begin
      readValue[slt_pkg::CTRL_EN_BIT]    = serialLinkEnable_reg;
      readValue[slt_pkg::CTRL_LINKB_BIT] = linkBSide_reg;
      readValue[slt_pkg::CTRL_CODE_BIT]  = linkModeIs8b10b_reg;
    end else if (s_axi_araddr == ADDR_WIDTH'(slt_pkg::STAT_ADDR)) begin
      // pattern actually in force after the coding check
      readValue[3:0] = laneCfg.source;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= slt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readValue;
        s_axi_rresp  <= readHit ? slt_pkg::RESP_OKAY : slt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pattern decode
  always_comb begin
    laneCfg_next = '{source: slt_pkg::SRC_DATA, prbsOrder: 5'h00, character: 8'h00, isControl: 1'b0};
    unique case (linkTestPatternSelect_reg)
      slt_pkg::TP_NORMAL:    laneCfg_next.source = slt_pkg::SRC_DATA;
      slt_pkg::TP_PRBS7: begin
        laneCfg_next.source    = slt_pkg::SRC_PRBS;
        laneCfg_next.prbsOrder = 5'h07;
      end
      slt_pkg::TP_PRBS15: begin
        laneCfg_next.source    = slt_pkg::SRC_PRBS;
        laneCfg_next.prbsOrder = 5'h0f;
      end
      slt_pkg::TP_PRBS23: begin
        laneCfg_next.source    = slt_pkg::SRC_PRBS;
        laneCfg_next.prbsOrder = 5'h17;
      end
      slt_pkg::TP_PRBS9: begin
        laneCfg_next.source    = slt_pkg::SRC_PRBS;
        laneCfg_next.prbsOrder = 5'h09;
      end
      slt_pkg::TP_PRBS31: begin
        laneCfg_next.source    = slt_pkg::SRC_PRBS;
        laneCfg_next.prbsOrder = 5'h1f;
      end
      slt_pkg::TP_RAMP:      laneCfg_next.source = slt_pkg::SRC_RAMP;
      slt_pkg::TP_TRANSPORT: laneCfg_next.source = slt_pkg::SRC_TRANSPORT;
      slt_pkg::TP_D21_5: begin
        laneCfg_next.source    = slt_pkg::SRC_CHAR;
        laneCfg_next.character = slt_pkg::CHAR_D21_5;
      end
      slt_pkg::TP_K28_5: begin
        if (linkModeIs8b10b_reg) begin
          laneCfg_next.source    = slt_pkg::SRC_CHAR;
          laneCfg_next.character = slt_pkg::CHAR_K28_5;
          laneCfg_next.isControl = 1'b1;
        end
      end
      slt_pkg::TP_K28_7: begin
        if (linkModeIs8b10b_reg) begin
          laneCfg_next.source    = slt_pkg::SRC_CHAR;
          laneCfg_next.character = slt_pkg::CHAR_K28_7;
          laneCfg_next.isControl = 1'b1;
        end
      end
      slt_pkg::TP_ILA_REP: begin
        if (linkModeIs8b10b_reg) begin
          laneCfg_next.source = slt_pkg::SRC_ILA;
        end
      end
      slt_pkg::TP_RPAT: begin
        if (linkModeIs8b10b_reg) begin
          laneCfg_next.source = slt_pkg::SRC_RPAT;
        end
      end
      slt_pkg::TP_LOW:       laneCfg_next.source = slt_pkg::SRC_LOW;
      slt_pkg::TP_HIGH:      laneCfg_next.source = slt_pkg::SRC_HIGH;
      slt_pkg::TP_CLOCK:     laneCfg_next.source = slt_pkg::SRC_CLOCK;
      default:               laneCfg_next.source = slt_pkg::SRC_DATA;
    endcase
  end

  // identifier and end-of-frame comma
  always_comb begin
    ilaCfg_next.linkIdA   = ilaLinkIdentifier_reg;
    ilaCfg_next.linkIdB   = 8'(ilaLinkIdentifier_reg + 8'h01);
    ilaCfg_next.eofEnable = linkModeIs8b10b_reg && endOfFrameCommaSelect_reg != 2'h3;
    unique case (endOfFrameCommaSelect_reg)
      2'h0:    ilaCfg_next.eofChar = slt_pkg::CHAR_K28_7;
      2'h1:    ilaCfg_next.eofChar = slt_pkg::CHAR_K28_1;
      2'h2:    ilaCfg_next.eofChar = slt_pkg::CHAR_K28_5;
      default: ilaCfg_next.eofChar = slt_pkg::CHAR_K28_7;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      laneCfg <= '{source: slt_pkg::SRC_DATA, prbsOrder: 5'h00, character: 8'h00, isControl: 1'b0};
    end else begin
      laneCfg <= laneCfg_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ilaCfg <= '{linkIdA: 8'h00, linkIdB: 8'h01, eofChar: slt_pkg::CHAR_K28_7, eofEnable: 1'b1};
    end else begin
      ilaCfg <= ilaCfg_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      serialLinkEnable <= 1'b0;
    end else begin
      serialLinkEnable <= serialLinkEnable_reg;
    end
  end

endmodule // slt_test_ila_ctrl

/* verif/slt_test_ila_monitor.sv */
`timescale 1ns/1ps
module slt_test_ila_monitor #(
  parameter int ADDR_WIDTH = 14
) (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic [ADDR_WIDTH-1:0]  s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire slt_pkg::slt_lane_cfg_t laneCfg,
  input wire slt_pkg::slt_ila_cfg_t  ilaCfg
);
  logic [ADDR_WIDTH-1:0] addr_reg;
  logic [7:0]            data_reg;
  logic                  strb_reg;
  logic                  bLast_reg;
  logic                  wrOk;
  logic                  testWr;
  // a write counts once, on the first cycle of its response
  assign wrOk = s_axi_bvalid && !bLast_reg && strb_reg && s_axi_bresp == slt_pkg::RESP_OKAY;
  assign testWr = wrOk && addr_reg == slt_pkg::TEST_ADDR;
  always_ff @(posedge clock) begin
    if (!reset_n) bLast_reg <= 1'b0;
    else bLast_reg <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) addr_reg <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) data_reg <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) strb_reg <= s_axi_wstrb[0];
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_reset;
    $rose(reset_n) |-> laneCfg.source == slt_pkg::SRC_DATA && ilaCfg.eofChar == slt_pkg::CHAR_K28_7;
  endproperty
  a_reset: assert property (p_reset) else $error("not normal after reset");
  property p_low;
    testWr && data_reg[4:0] == 5'h0a |=> laneCfg.source == slt_pkg::SRC_LOW;
  endproperty
  a_low: assert property (p_low) else $error("low level not selected");
  property p_clock;
    testWr && data_reg[4:0] == 5'h0f |=> laneCfg.source == slt_pkg::SRC_CLOCK;
  endproperty
  a_clock: assert property (p_clock) else $error("clock pattern not selected");
  property p_reserved;
    testWr && (data_reg[4:0] == 5'h0c || data_reg[4:0] > 5'h10) |=> laneCfg.source == slt_pkg::SRC_DATA;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved select left normal data");
  property p_id_even;
    ilaCfg.linkIdA[0] == 1'b0;
  endproperty
  a_id_even: assert property (p_id_even) else $error("identifier odd");
  property p_id_b;
    ilaCfg.linkIdB == ilaCfg.linkIdA + 8'h01;
  endproperty
  a_id_b: assert property (p_id_b) else $error("second link identifier wrong");
  property p_id_wr;
    wrOk && addr_reg == slt_pkg::LINKID_ADDR |=> ilaCfg.linkIdA == {data_reg[7:1], 1'b0};
  endproperty
  a_id_wr: assert property (p_id_wr) else $error("identifier not taken");
  property p_eof_res;
    wrOk && addr_reg == slt_pkg::COMMA_ADDR && data_reg[1:0] == 2'h3 |=> !ilaCfg.eofEnable;
  endproperty
  a_eof_res: assert property (p_eof_res) else $error("reserved comma choice in use");
  c_test_write: cover property (testWr);
  c_char: cover property (laneCfg.source == slt_pkg::SRC_CHAR);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == slt_pkg::RESP_SLVERR);
endmodule // slt_test_ila_monitor

bind slt_test_ila_ctrl slt_test_ila_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_slt_test_ila_monitor (.clock, .reset_n,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .laneCfg, .ilaCfg);

/* verif/slt_rx_model.sv */
`timescale 1ns/1ps
module slt_rx_model (
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire slt_pkg::slt_ila_cfg_t ilaCfg,
  input wire logic                  serialLinkEnable,
  output logic [7:0]                rxLinkId,
  output logic                      commaOk
);
  // generic receiver: may lock onto a false comma next to K28.7
  assign commaOk = !ilaCfg.eofEnable || ilaCfg.eofChar != slt_pkg::CHAR_K28_7;
  always_ff @(posedge clock) begin
    if (!reset_n) rxLinkId <= 8'h00;
    else if (serialLinkEnable) rxLinkId <= ilaCfg.linkIdA;
  end
endmodule // slt_rx_model

/* verif/test_serial_link_test_and_ila_params.sv */
`timescale 1ns/1ps
module test_serial_link_test_and_ila_params;
  localparam logic [1:0] OKAY = slt_pkg::RESP_OKAY;
  logic                   clock, reset_n = 1'b0;
  logic [13:0]            s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]             s_axi_wstrb = 4'h0;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  slt_pkg::slt_lane_cfg_t laneCfg;
  slt_pkg::slt_ila_cfg_t  ilaCfg;
  logic                   serialLinkEnable, commaOk;
  logic [7:0]             rxLinkId;
  int                     failures = 0, tests_run = 0, cycles = 0;
  slt_test_ila_ctrl i_slt_test_ila_ctrl (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .laneCfg, .ilaCfg, .serialLinkEnable);
  slt_rx_model i_slt_rx_model (.clock, .reset_n, .ilaCfg, .serialLinkEnable, .rxLinkId, .commaOk);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ready and valid are registered, so the falling edge sees what the next rising edge samples
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    @(posedge clock);
    check(r, er, "write response");
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
    @(posedge clock);
    check(d, ed, "read data");
    check(r, er, "read response");
  endtask
  function automatic slt_pkg::slt_source_t expSrc(input logic [4:0] s, input logic m);
    case (s)
      5'h01, 5'h02, 5'h03, 5'h0d, 5'h0e: return slt_pkg::SRC_PRBS;
      5'h04: return slt_pkg::SRC_RAMP;
      5'h05: return slt_pkg::SRC_TRANSPORT;
      5'h06: return slt_pkg::SRC_CHAR;
      5'h07, 5'h10: return m ? slt_pkg::SRC_CHAR : slt_pkg::SRC_DATA;
      5'h08: return m ? slt_pkg::SRC_ILA : slt_pkg::SRC_DATA;
      5'h09: return m ? slt_pkg::SRC_RPAT : slt_pkg::SRC_DATA;
      5'h0a: return slt_pkg::SRC_LOW;
      5'h0b: return slt_pkg::SRC_HIGH;
      5'h0f: return slt_pkg::SRC_CLOCK;
      default: return slt_pkg::SRC_DATA;
    endcase
  endfunction
  task automatic testReset;
    rd(slt_pkg::TEST_ADDR, 32'h0, OKAY);
    rd(slt_pkg::LINKID_ADDR, 32'h0, OKAY);
    rd(slt_pkg::COMMA_ADDR, 32'h0, OKAY);
    rd(slt_pkg::CTRL_ADDR, 32'h4, OKAY);
    @(negedge clock);
    check(laneCfg.source, slt_pkg::SRC_DATA, "source");
    check(ilaCfg.linkIdB, 8'h01, "link B id");
    @(posedge clock);
  endtask
  // m selects 8b/10b coding; the link stays disabled while settings change
  task automatic testPatterns(input logic m);
    logic [5:0] n;
    logic [4:0] s;
    wr(slt_pkg::CTRL_ADDR, {29'h0, m, 2'b00}, 4'h1, OKAY);
    for (n = 6'h00; n < 6'h20; n++) begin
      s = n[4:0];
      wr(slt_pkg::TEST_ADDR, {27'h0, s}, 4'h1, OKAY);
      rd(slt_pkg::TEST_ADDR, {27'h0, s}, OKAY);
      rd(slt_pkg::STAT_ADDR, {28'h0, expSrc(s, m)}, OKAY);
      @(negedge clock);
      check(ilaCfg.eofEnable, m, "comma insertion");
      check(laneCfg.source, expSrc(s, m), "source");
      if (expSrc(s, m) == slt_pkg::SRC_PRBS)
        check(laneCfg.prbsOrder, s == 5'h01 ? 5'h07 : s == 5'h02 ? 5'h0f : s == 5'h03 ? 5'h17 :
          s == 5'h0d ? 5'h09 : 5'h1f, "prbs order");
      if (expSrc(s, m) == slt_pkg::SRC_CHAR)
        check({laneCfg.isControl, laneCfg.character}, s == 5'h06 ? {1'b0, slt_pkg::CHAR_D21_5} :
          s == 5'h07 ? {1'b1, slt_pkg::CHAR_K28_5} : {1'b1, slt_pkg::CHAR_K28_7}, "character");
      @(posedge clock);
    end
  endtask
  task automatic testLinkId;
    wr(slt_pkg::LINKID_ADDR, 32'hff, 4'h1, OKAY);
    rd(slt_pkg::LINKID_ADDR, 32'hfe, OKAY);
    wr(slt_pkg::LINKID_ADDR, 32'h35, 4'h1, OKAY);
    wr(slt_pkg::LINKID_ADDR, 32'h12, 4'h0, OKAY);
    rd(slt_pkg::LINKID_ADDR, 32'h34, OKAY);
    wr(slt_pkg::CTRL_ADDR, 32'h7, 4'h1, OKAY);
    rd(slt_pkg::CTRL_ADDR, 32'h7, OKAY);
    repeat (2) @(negedge clock);
    check(ilaCfg.linkIdB, 8'h35, "link B id");
    check(serialLinkEnable, 1'b1, "link enable");
    check(rxLinkId, 8'h34, "received id");
    @(posedge clock);
    wr(slt_pkg::CTRL_ADDR, 32'h4, 4'h1, OKAY);
  endtask
  task automatic testComma;
    logic [2:0] v;
    for (v = 3'h0; v < 3'h4; v++) begin
      wr(slt_pkg::COMMA_ADDR, {30'h0, v[1:0]}, 4'h1, OKAY);
      rd(slt_pkg::COMMA_ADDR, {30'h0, v[1:0]}, OKAY);
      @(negedge clock);
      check(ilaCfg.eofEnable, v != 3'h3, "comma enable");
      if (v != 3'h3) check(ilaCfg.eofChar, v == 3'h0 ? slt_pkg::CHAR_K28_7 : v == 3'h1 ?
        slt_pkg::CHAR_K28_1 : slt_pkg::CHAR_K28_5, "comma");
      check(commaOk, v != 3'h0, "receiver lock");
      @(posedge clock);
    end
    wr(slt_pkg::COMMA_ADDR, 32'h0, 4'h1, OKAY);
    wr(14'h0000, 32'h1, 4'h1, slt_pkg::RESP_SLVERR);
    rd(14'h0000, 32'h0, slt_pkg::RESP_SLVERR);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    testReset();
    testPatterns(1'b1);
    testPatterns(1'b0);
    testLinkId();
    testComma();
    results();
  end
endmodule // test_serial_link_test_and_ila_params
